/* shared/iepc_pkg.sv */
// iepc_pkg: constants and types shared by the interrupt enable/priority ends
// assumes word-indexed registers, byte address is four times the index
`default_nettype none
package iepc_pkg;
   // register indices (byte address = 4 * index)
   localparam logic [11:0] IDX_G2_HI = 12'hFC7;
   localparam logic [11:0] IDX_G2_LO = 12'hFC8;
   localparam logic [11:0] IDX_EDGE_POL = 12'hFCD;
   localparam logic [11:0] IDX_SHARED_SEL = 12'hFCE;
   localparam logic [11:0] IDX_CTL = 12'hFCF;
   localparam logic [11:0] IDX_PORT_SEL = 12'hFD0;
   localparam logic [11:0] IDX_IRQ_STAT = 12'hFD1;
   localparam logic [11:0] IDX_IRQ_CLR = 12'hFD2;
   localparam logic [11:0] IDX_IRQ_EN = 12'hFD3;
   localparam logic [11:0] IDX_G2_PEND = 12'hFD4;

   // reset values
   localparam logic [7:0] RST_REG8 = 8'h00;
   localparam logic [3:0] RST_PEND = 4'h0;

   // field positions and widths
   localparam int NUM_GRP2 = 4;
   localparam int NUM_PADS = 8;
   localparam int SHARED_BIT = 6;
   localparam int MASTER_EN_BIT = 7;
   localparam logic [6:0] CTL_RSVD_RD = 7'h00;
   localparam logic [23:0] BUS_PAD = 24'h000000;

   // priority level encodings {high, low}
   typedef enum logic [1:0] {
      IEPC_LVL_OFF = 2'h0,
      IEPC_LVL_LOW = 2'h1,
      IEPC_LVL_NOM = 2'h2,
      IEPC_LVL_HIGH = 2'h3
   } iepc_level_t;

   // processor-side service states
   typedef enum logic [2:0] {
      IEPC_ST_IDLE = 3'h1,
      IEPC_ST_ACK = 3'h2,
      IEPC_ST_SERVICE = 3'h4
   } iepc_state_t;
endpackage : iepc_pkg
`default_nettype wire

/* shared/iepc_link_if.sv */
// iepc_link_if: link between the interrupt controller and the processor core
// assumes both ends share core_clk; all strobes are one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
interface iepc_link_if;
   logic req_valid;
   logic [1:0] req_index;
   logic [1:0] req_level;
   logic ack;
   logic [1:0] ack_index;
   logic enable_interrupts_instruction;
   logic disable_interrupts_instruction;
   logic interrupt_return_instruction;

   modport dev (
      output req_valid,
      output req_index,
      output req_level,
      input ack,
      input ack_index,
      input enable_interrupts_instruction,
      input disable_interrupts_instruction,
      input interrupt_return_instruction
   );

   modport cpu (
      input req_valid,
      input req_index,
      input req_level,
      output ack,
      output ack_index,
      output enable_interrupts_instruction,
      output disable_interrupts_instruction,
      output interrupt_return_instruction
   );
endinterface : iepc_link_if
`default_nettype wire

/* src/iepc_edge_det.sv */
// iepc_edge_det: one-bit edge detector with selectable polarity
// assumes the input is synchronous to core_clk
`timescale 1ns/10ps
`default_nettype none
module iepc_edge_det
   import iepc_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic sig_in,
   input wire logic rise_sel,
   output logic pulse_r
);
   logic prev_r;
   logic pulse_nxt;

   // rising edge when set, falling edge when clear
   assign pulse_nxt = rise_sel ? (sig_in & ~prev_r) : (~sig_in & prev_r);

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         prev_r <= 1'b0;
         pulse_r <= 1'b0;
      end else begin
         prev_r <= sig_in;
         pulse_r <= pulse_nxt;
      end
   end
endmodule : iepc_edge_det
`default_nettype wire

/* src/iepc_dev_end.sv */
// iepc_dev_end: interrupt enable, priority and source configuration
// assumes an Avalon-MM master with waitrequest and a processor core on the link
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
module iepc_dev_end
   import iepc_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [13:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [7:0] porta_pin_input,
   input wire logic [7:0] portd_pin_input,
   input wire logic comparator_out,
   input wire logic [3:0] portc_pin_input,
   output logic [7:0] shared_pin_requests,
   output logic irq_out,
   iepc_link_if.dev link
);
   // configuration registers
   logic [7:0] g2_hi_r;
   logic [7:0] g2_lo_r;
   logic [7:0] edge_pol_r;
   logic [7:0] shared_sel_r;
   logic [7:0] port_sel_r;
   logic master_en_r;

   // interrupt reporting registers
   logic [7:0] irq_stat_r;
   logic [7:0] irq_en_r;

   // request state
   logic [3:0] g2_pend_r;
   logic [3:0] pc_pulse;
   logic [3:0] ack_mask;
   logic [7:0] pad_src;

   // bus slave state
   logic done_r;
   logic [31:0] rdata_r;
   logic acc;
   logic aligned;
   logic [11:0] idx;
   logic wr_en;
   logic [7:0] wbyte;
   logic [7:0] rd_mux;

   // priority resolution
   logic [1:0] best_idx;
   logic [1:0] best_lvl;
   logic [1:0] lvl_i;
   logic found;

   // master enable control
   logic me_set;
   logic me_clr;

   // request outputs
   logic req_valid_r;
   logic [1:0] req_index_r;
   logic [1:0] req_level_r;

   // bus slave: one wait cycle, then the answer
   assign acc = avs_read | avs_write;
   assign avs_waitrequest = acc & ~done_r;
   assign aligned = (avs_address[1:0] == 2'h0);
   assign idx = avs_address[13:2];
   assign wr_en = avs_write & done_r & avs_byteenable[0] & aligned;
   assign wbyte = avs_writedata[7:0];
   assign avs_readdata = rdata_r;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         done_r <= 1'b0;
      end else begin
         done_r <= acc & ~done_r;
      end
   end

   // read mux, unmapped and write-only indices read zero
   always_comb begin
      rd_mux = RST_REG8;
      if (aligned) begin
         case (idx)
            IDX_G2_HI: rd_mux = g2_hi_r;
            IDX_G2_LO: rd_mux = g2_lo_r;
            IDX_EDGE_POL: rd_mux = edge_pol_r;
            IDX_SHARED_SEL: rd_mux = shared_sel_r;
            IDX_CTL: rd_mux = {master_en_r, CTL_RSVD_RD};
            IDX_PORT_SEL: rd_mux = port_sel_r;
            IDX_IRQ_STAT: rd_mux = irq_stat_r;
            IDX_IRQ_EN: rd_mux = irq_en_r;
            IDX_G2_PEND: rd_mux = {4'h0, g2_pend_r};
            default: rd_mux = RST_REG8;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rdata_r <= 32'h00000000;
      end else if (avs_read && !done_r) begin
         rdata_r <= {BUS_PAD, rd_mux};
      end
   end

   // plain read/write configuration registers
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         g2_hi_r <= RST_REG8;
         g2_lo_r <= RST_REG8;
         edge_pol_r <= RST_REG8;
         shared_sel_r <= RST_REG8;
         port_sel_r <= RST_REG8;
         irq_en_r <= RST_REG8;
      end else if (wr_en) begin
         case (idx)
            IDX_G2_HI: g2_hi_r <= wbyte;
            IDX_G2_LO: g2_lo_r <= wbyte;
            IDX_EDGE_POL: edge_pol_r <= wbyte;
            IDX_SHARED_SEL: shared_sel_r <= wbyte;
            IDX_PORT_SEL: port_sel_r <= wbyte;
            IDX_IRQ_EN: irq_en_r <= wbyte;
            default: ;
         endcase
      end
   end

   // master enable: sets win over clears in the same cycle
   assign me_set = link.enable_interrupts_instruction | link.interrupt_return_instruction
      | (wr_en & (idx == IDX_CTL) & wbyte[MASTER_EN_BIT]);
   assign me_clr = link.disable_interrupts_instruction | link.ack
      | (wr_en & (idx == IDX_CTL) & ~wbyte[MASTER_EN_BIT]);

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         master_en_r <= 1'b0;
      end else if (me_set) begin
         master_en_r <= 1'b1;
      end else if (me_clr) begin
         master_en_r <= 1'b0;
      end
   end

   // pad sources: port A or D per bit, bit 6 may be the comparator
   always_comb begin
      for (int i = 0; i < NUM_PADS; i++) begin
         pad_src[i] = port_sel_r[i] ? portd_pin_input[i] : porta_pin_input[i];
      end
      // the detector sees the muxed level, so a switch can make an edge
      if (shared_sel_r[SHARED_BIT]) begin
         pad_src[SHARED_BIT] = comparator_out;
      end
   end

   // edge detectors for pads and port C sources
   genvar g;
   generate
      for (g = 0; g < NUM_PADS; g++) begin : g_pad
         iepc_edge_det u_pad_det (
            .core_clk(core_clk),
            .nrst(nrst),
            .sig_in(pad_src[g]),
            .rise_sel(edge_pol_r[g]),
            .pulse_r(shared_pin_requests[g])
         );
      end
      for (g = 0; g < NUM_GRP2; g++) begin : g_pc
         iepc_edge_det u_pc_det (
            .core_clk(core_clk),
            .nrst(nrst),
            .sig_in(portc_pin_input[g]),
            .rise_sel(1'b1),
            .pulse_r(pc_pulse[g])
         );
      end
   endgenerate

   // port C pending bits, new request wins over acknowledge
   assign ack_mask = link.ack ? 4'(4'h1 << link.ack_index) : 4'h0;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         g2_pend_r <= RST_PEND;
      end else begin
         g2_pend_r <= (g2_pend_r & ~ack_mask) | pc_pulse;
      end
   end

   // highest level wins, lowest index breaks a tie
   always_comb begin
      best_idx = 2'h0;
      best_lvl = IEPC_LVL_OFF;
      lvl_i = IEPC_LVL_OFF;
      found = 1'b0;
      for (int i = 0; i < NUM_GRP2; i++) begin
         lvl_i = {g2_hi_r[i], g2_lo_r[i]};
         if (g2_pend_r[i] && (lvl_i > best_lvl)) begin
            best_lvl = lvl_i;
            best_idx = 2'(i);
            found = 1'b1;
         end
      end
   end

   // request presented only while the master enable is set
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         req_valid_r <= 1'b0;
         req_index_r <= 2'h0;
         req_level_r <= IEPC_LVL_OFF;
      end else begin
         req_valid_r <= found & master_en_r & ~me_clr & ~link.ack;
         req_index_r <= best_idx;
         req_level_r <= best_lvl;
      end
   end

   assign link.req_valid = req_valid_r;
   assign link.req_index = req_index_r;
   assign link.req_level = req_level_r;

   // sticky pad event status, set wins over clear
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         irq_stat_r <= RST_REG8;
      end else if (wr_en && (idx == IDX_IRQ_CLR)) begin
         irq_stat_r <= (irq_stat_r & ~wbyte) | shared_pin_requests;
      end else begin
         irq_stat_r <= irq_stat_r | shared_pin_requests;
      end
   end

   assign irq_out = |(irq_stat_r & irq_en_r);
endmodule : iepc_dev_end
`default_nettype wire

/* src/iepc_cpu_end.sv */
// iepc_cpu_end: processor-side end that takes and services requests
// assumes the controller end on the same link and core_clk
`timescale 1ns/10ps
`default_nettype none
module iepc_cpu_end
   import iepc_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   iepc_link_if.cpu link,
   input wire logic take_en,
   input wire logic exec_enable_interrupts,
   input wire logic exec_disable_interrupts,
   input wire logic svc_done,
   output logic svc_active,
   output logic [1:0] svc_index_r,
   output logic [1:0] svc_level_r
);
   iepc_state_t state_r;
   iepc_state_t state_nxt;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         IEPC_ST_IDLE: begin
            if (link.req_valid && take_en) begin
               state_nxt = IEPC_ST_ACK;
            end
         end
         IEPC_ST_ACK: state_nxt = IEPC_ST_SERVICE;
         IEPC_ST_SERVICE: begin
            if (svc_done) begin
               state_nxt = IEPC_ST_IDLE;
            end
         end
         default: state_nxt = IEPC_ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state_r <= IEPC_ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // latch the presented source when it is taken
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         svc_index_r <= 2'h0;
         svc_level_r <= IEPC_LVL_OFF;
      end else if (state_r == IEPC_ST_IDLE && link.req_valid && take_en) begin
         svc_index_r <= link.req_index;
         svc_level_r <= link.req_level;
      end
   end

   // acknowledge clears the master enable in the controller
   assign link.ack = (state_r == IEPC_ST_ACK);
   assign link.ack_index = svc_index_r;
   // software is expected to disable before switching shared sources
   assign link.disable_interrupts_instruction = exec_disable_interrupts;
   assign link.enable_interrupts_instruction = exec_enable_interrupts
      & (state_r == IEPC_ST_IDLE);
   assign link.interrupt_return_instruction = (state_r == IEPC_ST_SERVICE) & svc_done;
   assign svc_active = (state_r != IEPC_ST_IDLE);
endmodule : iepc_cpu_end
`default_nettype wire

/* tb/iepc_props.sv */
// iepc_props: link checks between the controller end and the processor end
// assumes one clock domain and the link signals as plain inputs
`timescale 1ns/10ps
`default_nettype none
module iepc_props
   import iepc_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic req_valid,
   input wire logic [1:0] req_index,
   input wire logic [1:0] req_level,
   input wire logic ack,
   input wire logic [1:0] ack_index,
   input wire logic enable_interrupts_instruction,
   input wire logic disable_interrupts_instruction,
   input wire logic interrupt_return_instruction
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   sequence s_take; req_valid ##1 ack; endsequence
   sequence s_ack_quiet;
      ack ##1 (!enable_interrupts_instruction && !interrupt_return_instruction);
   endsequence
   sequence s_dis_quiet;
      (disable_interrupts_instruction && !enable_interrupts_instruction
         && !interrupt_return_instruction)
      ##1 (!enable_interrupts_instruction && !interrupt_return_instruction);
   endsequence
   property p_ack_has_req; ack |-> $past(req_valid); endproperty
   property p_ack_index; s_take |-> ack_index == $past(req_index); endproperty
   property p_ack_pulse; ack |=> !ack [*2]; endproperty
   property p_level_on; req_valid |-> req_level != IEPC_LVL_OFF; endproperty
   property p_drop_after_ack; ack |=> !req_valid; endproperty
   property p_off_after_ack; s_ack_quiet |=> !req_valid; endproperty
   property p_dis_blocks; s_dis_quiet |=> !req_valid; endproperty
   property p_no_ack_ret; !(ack && interrupt_return_instruction); endproperty
   a_ack_has_req: assert property (p_ack_has_req)
      else $error("ack without a request");
   a_ack_index: assert property (p_ack_index)
      else $error("ack index differs from presented index");
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack longer than one cycle");
   a_level_on: assert property (p_level_on)
      else $error("disabled level presented");
   a_drop_after_ack: assert property (p_drop_after_ack)
      else $error("request still up after ack");
   a_off_after_ack: assert property (p_off_after_ack)
      else $error("request while master enable clear");
   a_dis_blocks: assert property (p_dis_blocks)
      else $error("request after disable");
   a_no_ack_ret: assert property (p_no_ack_ret)
      else $error("ack and return together");
endmodule : iepc_props
`default_nettype wire

/* tb/interrupt_enable_priority_control_bench.sv */
// interrupt_enable_priority_control_bench: both ends joined over the link
// assumes the Avalon-MM master here and one 100 MHz clock
`timescale 1ns/10ps
`default_nettype none
module interrupt_enable_priority_control_bench
   import iepc_pkg::*;
;
   logic core_clk, nrst, avs_read, avs_write, comparator_out, irq_out;
   logic take_en, exec_enable_interrupts, exec_disable_interrupts, svc_done, svc_active;
   logic avs_waitrequest;
   localparam logic [2:0] P_EN = 3'h1, P_DIS = 3'h2, P_DONE = 3'h4;
   logic [13:0] avs_address;
   logic [3:0] avs_byteenable, portc_pin_input;
   logic [31:0] avs_writedata, avs_readdata;
   logic [7:0] porta_pin_input, portd_pin_input, shared_pin_requests, rd, seen;
   logic [1:0] svc_index_r, svc_level_r;
   int num_errors = 0, cmp_count = 0, cyc = 0;
   iepc_link_if link();
   iepc_dev_end iepc_dev_end_i (.core_clk(core_clk), .nrst(nrst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .porta_pin_input(porta_pin_input),
      .portd_pin_input(portd_pin_input), .comparator_out(comparator_out),
      .portc_pin_input(portc_pin_input), .shared_pin_requests(shared_pin_requests),
      .irq_out(irq_out), .link(link.dev));
   iepc_cpu_end iepc_cpu_end_i (.core_clk(core_clk), .nrst(nrst), .link(link.cpu),
      .take_en(take_en), .exec_enable_interrupts(exec_enable_interrupts),
      .exec_disable_interrupts(exec_disable_interrupts), .svc_done(svc_done),
      .svc_active(svc_active), .svc_index_r(svc_index_r), .svc_level_r(svc_level_r));
   iepc_props iepc_props_i (.core_clk(core_clk), .nrst(nrst), .req_valid(link.req_valid),
      .req_index(link.req_index), .req_level(link.req_level), .ack(link.ack),
      .ack_index(link.ack_index),
      .enable_interrupts_instruction(link.enable_interrupts_instruction),
      .disable_interrupts_instruction(link.disable_interrupts_instruction),
      .interrupt_return_instruction(link.interrupt_return_instruction));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic report_and_stop();
      if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         report_and_stop();
      end
   end
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic bus(input logic wr, input logic [11:0] idx, input logic [7:0] d);
      @(posedge core_clk);
      avs_address <= {idx, 2'h0};
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= {BUS_PAD, d};
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   task automatic rchk(input logic [11:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      chk("register", exp, rd);
   endtask : rchk
   task automatic pulse(input logic [2:0] m);
      @(posedge core_clk);
      {svc_done, exec_disable_interrupts, exec_enable_interrupts} <= m;
      @(posedge core_clk);
      {svc_done, exec_disable_interrupts, exec_enable_interrupts} <= 3'h0;
   endtask : pulse
   task automatic watch();
      seen = 8'h00;
      repeat (5) begin
         @(posedge core_clk);
         seen |= shared_pin_requests;
      end
   endtask : watch
   task automatic t_regs();
      rchk(IDX_G2_HI, RST_REG8);
      rchk(IDX_G2_LO, RST_REG8);
      rchk(IDX_EDGE_POL, RST_REG8);
      rchk(IDX_SHARED_SEL, RST_REG8);
      rchk(IDX_CTL, RST_REG8);
      bus(1'b1, IDX_G2_HI, 8'h05);
      rchk(IDX_G2_HI, 8'h05);
      bus(1'b1, IDX_G2_LO, 8'h03);
      rchk(IDX_G2_LO, 8'h03);
      bus(1'b1, IDX_SHARED_SEL, 8'h40);
      rchk(IDX_SHARED_SEL, 8'h40);
      bus(1'b1, IDX_SHARED_SEL, 8'h00);
      bus(1'b1, IDX_CTL, 8'h7F);
      rchk(IDX_CTL, 8'h00);
      bus(1'b1, 12'h000, 8'hFF);
      rchk(12'h000, 8'h00);
   endtask : t_regs
   task automatic t_master();
      pulse(P_EN);
      rchk(IDX_CTL, 8'h80);
      pulse(P_DIS);
      rchk(IDX_CTL, 8'h00);
      bus(1'b1, IDX_CTL, 8'h80);
      rchk(IDX_CTL, 8'h80);
      bus(1'b1, IDX_CTL, 8'h00);
      rchk(IDX_CTL, 8'h00);
   endtask : t_master
   task automatic t_priority();
      logic [1:0] exp_idx[3] = '{2'h2, 2'h1, 2'h0};
      logic [1:0] exp_lvl[3] = '{IEPC_LVL_HIGH, IEPC_LVL_NOM, IEPC_LVL_LOW};
      bus(1'b1, IDX_G2_HI, 8'h06);
      bus(1'b1, IDX_G2_LO, 8'h05);
      portc_pin_input <= 4'hF;
      repeat (4) @(posedge core_clk);
      chk("req_valid", 8'h00, link.req_valid);
      bus(1'b1, IDX_CTL, 8'h80);
      repeat (3) @(posedge core_clk);
      chk("req_index", 8'h02, link.req_index);
      chk("req_level", IEPC_LVL_HIGH, link.req_level);
      pulse(P_DIS);
      @(posedge core_clk);
      chk("req_valid", 8'h00, link.req_valid);
      rchk(IDX_CTL, 8'h00);
      bus(1'b1, IDX_CTL, 8'h80);
      repeat (3) @(posedge core_clk);
      take_en <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         for (int w = 0; w < 50 && svc_active !== 1'b0; w++) @(posedge core_clk);
         for (int w = 0; w < 50 && svc_active !== 1'b1; w++) @(posedge core_clk);
         chk("svc_index", exp_idx[k], svc_index_r);
         chk("svc_level", exp_lvl[k], svc_level_r);
         rchk(IDX_CTL, 8'h00);
         pulse(P_DONE);
      end
      repeat (4) @(posedge core_clk);
      chk("req_valid", 8'h00, link.req_valid);
      rchk(IDX_CTL, 8'h80);
      rchk(IDX_G2_PEND, 8'h08);
      take_en <= 1'b0;
   endtask : t_priority
   task automatic t_pads();
      bus(1'b1, IDX_EDGE_POL, 8'h4F);
      @(posedge core_clk) porta_pin_input <= 8'h11;
      watch();
      chk("pads", 8'h01, seen);
      @(posedge core_clk) porta_pin_input <= 8'h00;
      watch();
      chk("pads", 8'h10, seen);
      bus(1'b1, IDX_PORT_SEL, 8'h02);
      @(posedge core_clk) portd_pin_input <= 8'h02;
      watch();
      chk("pads", 8'h02, seen);
      comparator_out <= 1'b1;
      bus(1'b1, IDX_IRQ_EN, 8'h00);
      bus(1'b1, IDX_SHARED_SEL, 8'h40);
      watch();
      chk("pads", 8'h40, seen);
   endtask : t_pads
   task automatic t_irq();
      rchk(IDX_IRQ_STAT, 8'h53);
      chk("irq_out", 8'h00, irq_out);
      bus(1'b1, IDX_IRQ_EN, 8'h01);
      repeat (2) @(posedge core_clk);
      chk("irq_out", 8'h01, irq_out);
      bus(1'b1, IDX_IRQ_CLR, 8'h01);
      rchk(IDX_IRQ_STAT, 8'h52);
      chk("irq_out", 8'h00, irq_out);
      bus(1'b1, IDX_IRQ_EN, 8'h10);
      repeat (2) @(posedge core_clk);
      chk("irq_out", 8'h01, irq_out);
   endtask : t_irq
   task automatic t_reset();
      @(posedge core_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      rchk(IDX_CTL, 8'h00);
      rchk(IDX_IRQ_STAT, 8'h00);
      chk("irq_out", 8'h00, irq_out);
      rchk(IDX_G2_PEND, 8'h0F);
   endtask : t_reset
   initial begin
      nrst = 1'b0;
      {avs_read, avs_write, comparator_out, take_en} = 4'h0;
      {exec_enable_interrupts, exec_disable_interrupts, svc_done} = 3'h0;
      avs_address = 14'h0000;
      avs_byteenable = 4'hF;
      avs_writedata = 32'h00000000;
      {porta_pin_input, portd_pin_input, portc_pin_input} = 20'h00000;
      repeat (12) @(posedge core_clk);
      nrst <= 1'b1;
      t_regs();
      t_master();
      t_priority();
      t_pads();
      t_irq();
      t_reset();
      report_and_stop();
   end
endmodule : interrupt_enable_priority_control_bench
`default_nettype wire
